/* File: hw/npr_defs.vh */
// Constants for the host processor register port.
// Assumes one clock: the host port clock is the system clock.

`ifndef NPR_DEFS_VH
`define NPR_DEFS_VH

// Register indices on the six-bit address bus
`define NPR_IDX_CTRL 6'h00
`define NPR_IDX_CONFIG 6'h01
`define NPR_IDX_STATUS 6'h02
`define NPR_IDX_EVENT 6'h03
`define NPR_IDX_COMMAND 6'h04

// Reset values
`define NPR_CTRL_RST 16'h0000
`define NPR_CONFIG_RST 16'h0000
`define NPR_EVENT_RST 16'h0000
`define NPR_COMMAND_RST 16'h0000

// Event register field: access error bit
`define NPR_EVT_ERR_BIT 0

// Kinds of deferred update held for the core
`define NPR_KIND_WRITE 1'b1
`define NPR_KIND_CLEAR 1'b0

// Timing: clock period and bus turnaround, in ns
`define NPR_CLK_NS 25
`define NPR_TURN_NS 40
// Least time, so rounded up to whole cycles
`define NPR_TURN_CYC ((`NPR_TURN_NS + `NPR_CLK_NS - 1) / `NPR_CLK_NS)

`endif

/* File: hw/npr_hold.v */
// Single input holding register between the port and the core.
// Assumes byte_clock_run_in comes from logic on the same clock.
`timescale 1ns/1ps
`include "npr_defs.vh"

module npr_hold
(
  input wire clk_sys_in,
  input wire srst_in,
  input wire req_in,
  input wire kind_in,
  input wire [5:0] idx_in,
  input wire [15:0] data_in,
  input wire byte_clock_run_in,
  output wire apply_out,
  output wire kind_out,
  output wire [5:0] idx_out,
  output wire [15:0] data_out
);

  // Held update contents
  reg valid_q;
  reg kind_q;
  reg [5:0] idx_q;
  reg [15:0] data_q;

  // Update leaves only while the core's byte clock runs
  assign apply_out = valid_q & byte_clock_run_in;
  assign kind_out = kind_q;
  assign idx_out = idx_q;
  assign data_out = data_q;

  // Only one slot: a newer request overwrites an unapplied one,
  // so with the byte clock stopped only the last one survives
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      valid_q <= 1'b0;
      kind_q <= `NPR_KIND_CLEAR;
      idx_q <= 6'h00;
      data_q <= 16'h0000;
    end
    else if (req_in)
    begin
      // New request reloads the slot even on the edge the old one is applied
      valid_q <= 1'b1;
      kind_q <= kind_in;
      idx_q <= idx_in;
      data_q <= data_in;
    end
    else if (apply_out)
    begin
      // Consumed by the register file
      valid_q <= 1'b0;
    end
  end

endmodule

/* File: hw/npr_port.v */
// Host processor register port: sequencing, turnaround, registers.
// Assumes port pins are synchronous to clk_sys_in (same clock as
// the core), so they are sampled directly without synchronisers.
`timescale 1ns/1ps
`include "npr_defs.vh"

module npr_port
(
  input wire clk_sys_in,
  input wire srst_in,
  input wire reg_select_n_in,
  input wire [5:0] reg_addr_in,
  input wire read_not_write_in,
  input wire [15:0] host_data_in,
  output reg [15:0] host_data_out,
  output reg host_data_oe_out,
  input wire [15:0] status_in,
  input wire [14:0] core_event_in,
  input wire core_idle_in,
  input wire byte_clock_run_in,
  output reg [15:0] ctrl_out,
  output reg [15:0] config_out,
  output reg [15:0] cmd_out,
  output reg cmd_strobe_out,
  output wire [15:0] event_out,
  output wire host_access_error_out
);

  // Sequencer states, one-hot
  localparam S_IDLE = 4'b0001;
  localparam S_READ = 4'b0010;
  localparam S_WRITE = 4'b0100;
  localparam S_WEND = 4'b1000;

  // Turnaround count, cut on purpose to the cycle counter's width
  localparam integer TURN_FULL = `NPR_TURN_CYC;
  localparam [2:0] TURN_CYC = TURN_FULL[2:0];

  // Sequencer state and its next value
  reg [3:0] state_q;
  reg [3:0] state_d;
  // Captured register index and access legality
  reg [5:0] idx_q;
  reg ok_q;
  // Edges since the first sampling edge, saturating
  reg [2:0] cyc_q;
  // Edges on which select was seen high during a read
  reg [1:0] hi_q;
  // Sticky event register
  reg [15:0] evt_q;

  // Select seen asserted at this edge
  wire sel_low;
  // First sampling edge of a new transaction
  wire start;
  // Legality of the access presented now
  wire legal_now;
  // Read drive may end at this edge
  wire release_rd;
  // Holding register request
  reg hreq;
  reg hkind;
  reg [15:0] hdata;
  // Holding register output
  wire apply;
  wire akind;
  wire [5:0] aidx;
  wire [15:0] adata;
  // Error flagged this edge
  wire err_set;
  // Bits cleared by a read of the event register
  wire [15:0] clr_mask;
  // Value that a read of the captured index returns
  reg [15:0] rd_val;

  // Which index exists and in which direction; a config write
  // is only allowed while the core reports idle
  function npr_legal;
    input [5:0] idx;
    input is_write;
    input cfg_ok;
    begin
      case (idx)
        `NPR_IDX_CTRL: npr_legal = 1'b1;
        `NPR_IDX_CONFIG: npr_legal = ~is_write | cfg_ok;
        `NPR_IDX_STATUS: npr_legal = ~is_write;
        `NPR_IDX_EVENT: npr_legal = ~is_write;
        `NPR_IDX_COMMAND: npr_legal = is_write;
        default: npr_legal = 1'b0;
      endcase
    end
  endfunction

  // Select is active low
  assign sel_low = ~reg_select_n_in;

  // Address and direction are only looked at on the edge where
  // select is first seen low from idle
  assign start = sel_low & (state_q == S_IDLE);

  // Direction is high for read, low for write
  assign legal_now = npr_legal(reg_addr_in, ~read_not_write_in,
    core_idle_in);

  // Release on the second edge with select seen high, but for a legal
  // read never before data has been driven for at least one cycle
  assign release_rd = ~sel_low & (hi_q != 2'd0) &
    (host_data_oe_out | ~ok_q);

  // Illegal access raises the error on its first edge
  assign err_set = start & ~legal_now;

  // Read-clear removes only the bits that were returned
  assign clr_mask = (apply & (akind == `NPR_KIND_CLEAR)) ?
    adata : 16'h0000;

  // Event register is visible to the core
  assign event_out = evt_q;
  assign host_access_error_out = evt_q[`NPR_EVT_ERR_BIT];

  // Next state of the sequencer
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (start)
        begin
          state_d = read_not_write_in ? S_READ : S_WRITE;
        end
      end
      S_READ:
      begin
        // Stays while select is held: wait states
        if (release_rd)
        begin
          state_d = S_IDLE;
        end
      end
      S_WRITE:
      begin
        // Write completes here whatever select does
        state_d = sel_low ? S_WEND : S_IDLE;
      end
      S_WEND:
      begin
        // Wait for deselect so one assertion is one access
        if (~sel_low)
        begin
          state_d = S_IDLE;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // Read multiplexer over the captured index
  always @*
  begin
    case (idx_q)
      `NPR_IDX_CTRL: rd_val = ctrl_out;
      `NPR_IDX_CONFIG: rd_val = config_out;
      `NPR_IDX_STATUS: rd_val = status_in;
      `NPR_IDX_EVENT: rd_val = evt_q;
      default: rd_val = 16'h0000;
    endcase
  end

  // Request for the holding register
  always @*
  begin
    hreq = 1'b0;
    hkind = `NPR_KIND_CLEAR;
    hdata = 16'h0000;
    if (state_q == S_WRITE && ok_q)
    begin
      // Write data taken at the second edge
      hreq = 1'b1;
      hkind = `NPR_KIND_WRITE;
      hdata = host_data_in;
    end
    else if (state_q == S_READ && cyc_q == 3'd1 && ok_q &&
      idx_q == `NPR_IDX_EVENT)
    begin
      // Snapshot goes to the host and then gets cleared
      hreq = 1'b1;
      hkind = `NPR_KIND_CLEAR;
      hdata = rd_val;
    end
  end

  // Sequencer registers and capture of address and direction
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      state_q <= S_IDLE;
      idx_q <= 6'h00;
      ok_q <= 1'b0;
      cyc_q <= 3'd0;
      hi_q <= 2'd0;
    end
    else
    begin
      state_q <= state_d;
      if (start)
      begin
        // First sampling edge
        idx_q <= reg_addr_in;
        ok_q <= legal_now;
        cyc_q <= 3'd1;
        hi_q <= 2'd0;
      end
      else
      begin
        // Saturating edge count
        if (cyc_q != 3'd7)
        begin
          cyc_q <= cyc_q + 3'd1;
        end
        // Count deselected edges in a read
        if (state_q == S_READ && ~sel_low && hi_q != 2'd3)
        begin
          hi_q <= hi_q + 2'd1;
        end
      end
    end
  end

  // Read data and bus drive
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      host_data_out <= 16'h0000;
      host_data_oe_out <= 1'b0;
    end
    else
    begin
      // Data is loaded at the second edge and then frozen
      if (state_q == S_READ && cyc_q == 3'd1)
      begin
        host_data_out <= ok_q ? rd_val : 16'h0000;
      end
      if (state_q != S_READ || release_rd)
      begin
        // Idle, write or end of read: bus left undriven
        host_data_oe_out <= 1'b0;
      end
      else if (ok_q && cyc_q >= TURN_CYC)
      begin
        // Drive only after the previous owner had time to let go;
        // illegal reads never drive at all
        host_data_oe_out <= 1'b1;
      end
    end
  end

  // Core facing registers, updated from the holding register
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ctrl_out <= `NPR_CTRL_RST;
      config_out <= `NPR_CONFIG_RST;
      cmd_out <= `NPR_COMMAND_RST;
      cmd_strobe_out <= 1'b0;
    end
    else
    begin
      cmd_strobe_out <= 1'b0;
      if (apply && akind == `NPR_KIND_WRITE)
      begin
        case (aidx)
          `NPR_IDX_CTRL: ctrl_out <= adata;
          `NPR_IDX_CONFIG: config_out <= adata;
          `NPR_IDX_COMMAND:
          begin
            // Write-only register: one pulse per write
            cmd_out <= adata;
            cmd_strobe_out <= 1'b1;
          end
          default:
          begin
            cmd_strobe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Sticky events: a new event wins over a read-clear that hits
  // the same bit on the clearing edge; one between read and clear on a returned bit is lost
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      evt_q <= `NPR_EVENT_RST;
    end
    else
    begin
      evt_q <= (evt_q & ~clr_mask) | {core_event_in, err_set};
    end
  end

  // Single holding register towards the core
  npr_hold npr_hold_inst
  (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .req_in(hreq),
    .kind_in(hkind),
    .idx_in(idx_q),
    .data_in(hdata),
    .byte_clock_run_in(byte_clock_run_in),
    .apply_out(apply),
    .kind_out(akind),
    .idx_out(aidx),
    .data_out(adata)
  );

endmodule

/* File: tb/npr_host_model.sv */
// Host bus model: drives select, address, direction and write data.
// Assumes the port samples on rising edges; this model moves on falling.
`timescale 1ns/1ps
module npr_host_model
(
  input wire clk_sys_in,
  input wire oe_in,
  input wire [15:0] rd_in,
  output reg sel_n_out,
  output reg [5:0] addr_out,
  output reg rw_out,
  output reg [15:0] wd_out
);
  // Idle and deselected at time zero
  initial
  begin
    sel_n_out = 1'b1;
    addr_out = 6'h00;
    rw_out = 1'b1;
    wd_out = 16'h0000;
  end
  // One access: h wait states, then t cycles watching the drive
  task access(input logic rw, input logic [5:0] a, input logic [15:0] d,
    input int h, input int t, output logic [15:0] rd, output int n);
    begin
      rd = 16'h0000;
      n = 0;
      @(negedge clk_sys_in);
      sel_n_out = 1'b0;
      addr_out = a;
      rw_out = rw;
      // A read leaves the bus released, so show inverted data
      wd_out = rw ? ~wd_out : d;
      // The drive is watched through the wait states as well
      for (int i = 0; i < h + 1 + t; i++)
      begin
        @(negedge clk_sys_in);
        if (oe_in === 1'b1)
        begin
          n++;
          rd = rd_in;
        end
        if (i == h)
        begin
          sel_n_out = 1'b1;
          addr_out = ~a;
        end
        else if (i > h)
        begin
          wd_out = ~d;
        end
      end
    end
  endtask
endmodule

/* File: tb/npr_port_properties.sv */
// Checker on the register port pins of npr_port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module npr_port_checker
(
  input wire clk_sys_in,
  input wire srst_in,
  input wire reg_select_n_in,
  input wire [5:0] reg_addr_in,
  input wire read_not_write_in,
  input wire [15:0] host_data_in,
  input wire [15:0] host_data_out,
  input wire host_data_oe_out,
  input wire core_idle_in,
  input wire byte_clock_run_in,
  input wire [15:0] ctrl_out,
  input wire cmd_strobe_out,
  input wire host_access_error_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  a_drive_after_read: assert property ($rose(host_data_oe_out) |->
    !$past(reg_select_n_in, 3) && $past(read_not_write_in, 3))
    else $error("drive without a read");
  a_read_drives: assert property ($fell(reg_select_n_in) &&
    read_not_write_in && reg_addr_in == 6'h02 |-> ##3 host_data_oe_out)
    else $error("read not driven");
  a_drive_release: assert property (reg_select_n_in [*3]
    |=> !host_data_oe_out) else $error("bus not released");
  a_data_steady: assert property (host_data_oe_out &&
    $past(host_data_oe_out) |-> $stable(host_data_out))
    else $error("read data moved");
  a_err_refused: assert property ($fell(reg_select_n_in) &&
    read_not_write_in && reg_addr_in == 6'h04 |-> ##[1:2]
    host_access_error_out) else $error("refused read unflagged");
  a_err_locked: assert property ($fell(reg_select_n_in) &&
    !read_not_write_in && reg_addr_in == 6'h01 && !core_idle_in
    |-> ##[1:2] host_access_error_out) else $error("locked write unflagged");
  a_ctrl_write: assert property ($fell(reg_select_n_in) &&
    !read_not_write_in && reg_addr_in == 6'h00 ##1 byte_clock_run_in [*2]
    |=> ctrl_out == $past(host_data_in, 2)) else $error("write lost");
  a_frozen_core: assert property (!byte_clock_run_in &&
    !$past(byte_clock_run_in) |-> $stable(ctrl_out))
    else $error("update while stopped");
  a_cmd_once: assert property (cmd_strobe_out |=>
    !cmd_strobe_out) else $error("command strobe too long");
  c_read: cover property ($rose(host_data_oe_out));
  c_error: cover property ($rose(host_access_error_out));
  c_stall: cover property (!reg_select_n_in [*4]);
endmodule

/* File: tb/npr_port_tb_top.sv */
// Bench for npr_port: the host model runs cycles, tasks judge them.
// Assumes npr_defs.vh on the include path.
`timescale 1ns/1ps
`include "npr_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  bad_count++; $display("Error %0t got %h exp %h", $time, g, e); end end
module npr_port_tb_top;
  logic clk_sys_in, srst_in, reg_select_n_in, read_not_write_in;
  logic host_data_oe_out, core_idle_in, byte_clock_run_in;
  logic host_access_error_out, cmd_strobe_out;
  logic [14:0] core_event_in;
  logic [5:0] reg_addr_in;
  logic [15:0] host_data_in, host_data_out, status_in, ctrl_out;
  logic [15:0] config_out, cmd_out, event_out, got;
  int bad_count, compares, n, strobes;
  npr_port npr_port_inst
  (
    .clk_sys_in, .srst_in, .reg_select_n_in, .reg_addr_in,
    .read_not_write_in, .host_data_in, .host_data_out,
    .host_data_oe_out, .status_in, .core_event_in,
    .core_idle_in, .byte_clock_run_in, .ctrl_out, .config_out,
    .cmd_out, .cmd_strobe_out, .event_out, .host_access_error_out
  );
  npr_host_model npr_host_model_inst
  (
    .clk_sys_in, .oe_in(host_data_oe_out), .rd_in(host_data_out),
    .sel_n_out(reg_select_n_in), .addr_out(reg_addr_in),
    .rw_out(read_not_write_in), .wd_out(host_data_in)
  );
  // 40 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // Count command strobes seen at rising edges
  always @(posedge clk_sys_in)
  begin
    if (cmd_strobe_out === 1'b1)
      strobes++;
  end
  task acc(input logic rw, input logic [5:0] a, input logic [15:0] d,
    input int h, input int t);
    npr_host_model_inst.access(rw, a, d, h, t, got, n);
  endtask
  // Writes two clocks apart, then a shortest read back
  task t_write_back;
    acc(1'b0, `NPR_IDX_CTRL, 16'ha5a5, 0, 0);
    acc(1'b0, `NPR_IDX_CONFIG, 16'h1234, 0, 0);
    acc(1'b0, `NPR_IDX_COMMAND, 16'h00c3, 0, 3);
    `CHK(ctrl_out, 16'ha5a5)
    `CHK(config_out, 16'h1234)
    `CHK(cmd_out, 16'h00c3)
    `CHK(strobes, 1)
    acc(1'b1, `NPR_IDX_CTRL, 16'h0000, 0, 6);
    `CHK(got, 16'ha5a5)
    `CHK(n, 1)
  endtask
  // Wait states stretch the drive, never below one cycle
  task t_wait_read;
    for (int h = 0; h < 4; h++)
    begin
      acc(1'b1, `NPR_IDX_STATUS, 16'h0000, h, 8);
      `CHK(got, 16'h5a3c)
      `CHK(n, (h > 1) ? h : 1)
    end
  endtask
  // Refused accesses: no drive, flag set, flag cleared on read
  task t_refused;
    logic [6:0] tb [5];
    tb = '{7'h44, 7'h7f, 7'h02, 7'h03, 7'h01};
    for (int i = 0; i < 5; i++)
    begin
      core_idle_in = (i != 4);
      acc(tb[i][6], tb[i][5:0], 16'hffff, 0, 6);
      `CHK(n, 0)
      `CHK(host_access_error_out, 1'b1)
      `CHK(event_out, 16'h0001)
      // One core event just before the read joins the error bit
      core_event_in = 15'h0001;
      @(negedge clk_sys_in);
      core_event_in = 15'h0000;
      acc(1'b1, `NPR_IDX_EVENT, 16'h0000, 0, 6);
      `CHK(got, 16'h0003)
      `CHK(host_access_error_out, 1'b0)
      `CHK(event_out, 16'h0000)
    end
    `CHK(config_out, 16'h1234)
    core_idle_in = 1'b1;
  endtask
  // Core stopped: reads still work, only the last write lands
  task t_stopped;
    byte_clock_run_in = 1'b0;
    acc(1'b0, `NPR_IDX_CTRL, 16'h1111, 0, 0);
    acc(1'b0, `NPR_IDX_CTRL, 16'h2222, 0, 3);
    `CHK(ctrl_out, 16'ha5a5)
    acc(1'b1, `NPR_IDX_STATUS, 16'h0000, 0, 6);
    `CHK(got, 16'h5a3c)
    byte_clock_run_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    `CHK(ctrl_out, 16'h2222)
  endtask
  task final_report;
    $display("Mismatches %0d of %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    bad_count = 0;
    compares = 0;
    strobes = 0;
    core_event_in = 15'h0000;
    srst_in = 1'b1;
    status_in = 16'h5a3c;
    core_idle_in = 1'b1;
    byte_clock_run_in = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    srst_in = 1'b0;
    `CHK(host_data_oe_out, 1'b0)
    t_write_back();
    t_wait_read();
    t_refused();
    t_stopped();
    final_report();
  end
endmodule
bind npr_port npr_port_checker npr_port_checker_inst
(
  .clk_sys_in, .srst_in, .reg_select_n_in, .reg_addr_in,
  .read_not_write_in, .host_data_in, .host_data_out, .host_data_oe_out,
  .core_idle_in, .byte_clock_run_in, .ctrl_out, .cmd_strobe_out,
  .host_access_error_out
);
